/* File: logic/hpsm_top.sv */
// port power control and strap selected pin functions
// Behaviour
// - low over-current input means over-current, high means none
// - over-current strap high: removable port; low: non-removable port
// - port-one pin strap: high power control, low fixed device reset
// - power outputs low turn VBUS on, high turn off
// - port-two power strap high individual control, low ganged control
// - clock pin is ROM serial clock or port-four indicator by strap
// - ROM select low selects ROM; its strap marks ROM presence
// - data-in pin receives ROM data or drives port-three indicator
// - data-out pin sends ROM data or drives port-two indicator
// - ROM data and clock straps decode LED, charging, address length
// - select strap low gives shared ROM pins their indicator functions
`timescale 1ns/1ps
`include "hpsm_params.svh"
module hpsm_top import hpsm_pkg::*; #(
    parameter int FIXED_RST_NS = `HPSM_FIXED_RST_NS
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [3:0] portx_overcurrent_n_i,
    input wire logic port1_pin_i,
    input wire logic port2_pin_i,
    input wire logic rom_serial_clock_i,
    input wire logic rom_select_n_i,
    input wire logic rom_data_in_i,
    input wire logic rom_data_out_i,
    input wire logic [3:0] port_power_req_i,
    input wire logic [3:0] port_indicator_req_i,
    input wire logic fixed_reset_req_i,
    input wire logic rom_sck_req_i,
    input wire logic rom_cs_req_i,
    input wire logic rom_mosi_req_i,
    output logic [3:0] port_overcurrent_o,
    output logic [3:0] port_fixed_o,
    output logic individual_mode_o,
    output logic rom_present_o,
    output logic [2:0] led_opts_o,
    output logic ready_o,
    output logic rom_miso_o,
    output logic port1_power_on_n_o,
    output logic port1_power_on_n_oe_o,
    output logic [2:0] portn_power_on_n_o,
    output logic [2:0] portn_power_on_n_oe_o,
    output logic rom_serial_clock_o,
    output logic rom_serial_clock_oe_o,
    output logic rom_select_n_o,
    output logic rom_select_n_oe_o,
    output logic rom_data_in_o,
    output logic rom_data_in_oe_o,
    output logic rom_data_out_o,
    output logic rom_data_out_oe_o
);
    localparam int RST_CYC =
        (FIXED_RST_NS * (`HPSM_CLK_HZ / 1000000) + 999) / 1000;
    localparam int CYC = (RST_CYC < 1) ? 1 : RST_CYC;
    if (CYC > 4096) begin : g_bad_cyc
        $error("fixed reset too long");
    end

    // ----------------------------------------
    // strap capture
    // ----------------------------------------
    hpsm_straps_t strap_q;
    hpsm_state_t state_q;
    logic [12:0] cnt_q;
    logic [3:0] pwr_d;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            strap_q <= '{removable: 4'hF, port1_is_power: `HPSM_STRAP_RST,
                individual: `HPSM_STRAP_RST, rom_present: `HPSM_STRAP_RST,
                led_opts: 3'h7};
        end else if (state_q == HPSM_SAMPLE) begin
            strap_q.removable <= portx_overcurrent_n_i;
            strap_q.port1_is_power <= port1_pin_i;
            strap_q.individual <= port2_pin_i;
            strap_q.rom_present <= rom_select_n_i;
            strap_q.led_opts <= {rom_serial_clock_i, rom_data_in_i,
                rom_data_out_i};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= HPSM_SAMPLE;
            cnt_q <= 13'h0000;
        end else begin
            unique case (state_q)
                HPSM_SAMPLE: begin
                    state_q <= HPSM_FIXRST;
                    cnt_q <= 13'h0000;
                end
                HPSM_FIXRST: begin
                    if (cnt_q == 13'(CYC - 1)) state_q <= HPSM_RUN;
                    else cnt_q <= cnt_q + 13'h0001;
                end
                HPSM_RUN: state_q <= HPSM_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // power and over-current
    // ----------------------------------------
    always_comb begin
        if (strap_q.individual) pwr_d = port_power_req_i;
        else pwr_d = {4{|port_power_req_i}};
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            port_overcurrent_o <= 4'h0;
            port_fixed_o <= 4'h0;
            individual_mode_o <= 1'b0;
            rom_present_o <= 1'b0;
            led_opts_o <= 3'h0;
            ready_o <= 1'b0;
            port1_power_on_n_o <= 1'b1;
            port1_power_on_n_oe_o <= 1'b0;
            portn_power_on_n_o <= 3'h7;
            portn_power_on_n_oe_o <= 3'h0;
        end else begin
            // only removable ports report, and not before straps latch
            port_overcurrent_o <= ~portx_overcurrent_n_i & strap_q.removable
                & {4{state_q != HPSM_SAMPLE}};
            port_fixed_o <= ~strap_q.removable;
            individual_mode_o <= strap_q.individual;
            rom_present_o <= strap_q.rom_present;
            led_opts_o <= strap_q.led_opts;
            ready_o <= (state_q == HPSM_RUN);
            portn_power_on_n_o <= ~pwr_d[3:1];
            portn_power_on_n_oe_o <= {3{state_q != HPSM_SAMPLE}};
            port1_power_on_n_oe_o <= (state_q != HPSM_SAMPLE);
            if (strap_q.port1_is_power) begin
                port1_power_on_n_o <= ~pwr_d[0];
            end else begin
                // fixed device held in reset until run, then by request
                port1_power_on_n_o <= (state_q == HPSM_RUN)
                    && !fixed_reset_req_i;
            end
        end
    end

    // ----------------------------------------
    // ROM / indicator pins
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rom_serial_clock_o <= 1'b1;
            rom_serial_clock_oe_o <= 1'b0;
            rom_select_n_o <= 1'b1;
            rom_select_n_oe_o <= 1'b0;
            rom_data_in_o <= 1'b1;
            rom_data_in_oe_o <= 1'b0;
            rom_data_out_o <= 1'b1;
            rom_data_out_oe_o <= 1'b0;
            rom_miso_o <= 1'b0;
        end else if (state_q == HPSM_SAMPLE) begin
            rom_serial_clock_oe_o <= 1'b0;
            rom_select_n_oe_o <= 1'b0;
            rom_data_in_oe_o <= 1'b0;
            rom_data_out_oe_o <= 1'b0;
        end else if (strap_q.rom_present) begin
            rom_serial_clock_o <= rom_sck_req_i;
            rom_serial_clock_oe_o <= 1'b1;
            rom_select_n_o <= ~rom_cs_req_i;
            rom_select_n_oe_o <= 1'b1;
            rom_data_in_oe_o <= 1'b0;
            rom_miso_o <= rom_data_in_i;
            rom_data_out_o <= rom_mosi_req_i;
            rom_data_out_oe_o <= 1'b1;
        end else begin
            rom_serial_clock_o <= ~port_indicator_req_i[3];
            rom_serial_clock_oe_o <= 1'b1;
            rom_select_n_o <= 1'b1;
            rom_select_n_oe_o <= 1'b0;
            rom_data_in_o <= ~port_indicator_req_i[2];
            rom_data_in_oe_o <= 1'b1;
            rom_data_out_o <= ~port_indicator_req_i[1];
            rom_data_out_oe_o <= 1'b1;
            rom_miso_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_oc_active_low: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) port_overcurrent_o[0] |-> $past(strap_q.removable[0])
        && !$past(portx_overcurrent_n_i[0]))
        else $error("over-current reported without low input");
    a_fixed_port: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) ~|(port_fixed_o & port_overcurrent_o))
        else $error("fixed port reports over-current");
    a_fixed_reset: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) !strap_q.port1_is_power && state_q == HPSM_FIXRST
        ##1 !strap_q.port1_is_power |-> !port1_power_on_n_o)
        else $error("fixed device reset not held");
    a_power_pol: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) state_q != HPSM_SAMPLE |=>
        portn_power_on_n_o[2] == !$past(pwr_d[3]))
        else $error("power output polarity wrong");
    a_gang_mode: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) !strap_q.individual && state_q == HPSM_RUN
        && $stable(strap_q.individual) |=> &portn_power_on_n_o
        || ~|portn_power_on_n_o)
        else $error("ganged ports differ");
    a_led4_sel: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) state_q == HPSM_RUN && !strap_q.rom_present
        |=> rom_serial_clock_o == !$past(port_indicator_req_i[3]))
        else $error("port four indicator wrong");
    a_cs_drive: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) state_q == HPSM_RUN && strap_q.rom_present
        |=> rom_select_n_o == !$past(rom_cs_req_i))
        else $error("rom select wrong");
    a_datain_dir: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) state_q == HPSM_RUN |=>
        rom_data_in_oe_o == !$past(strap_q.rom_present))
        else $error("data-in direction wrong");
    a_pins_hiz: assert property (@(posedge clk_sys_i) disable iff
        (srst_i) state_q == HPSM_SAMPLE |=> !rom_data_out_oe_o
        && !rom_serial_clock_oe_o)
        else $error("pin driven during strap sampling");
endmodule

/* File: pkg/hpsm_params.svh */
// timing counts and strap reset values for the port power strap mux
`ifndef HPSM_PARAMS_SVH
`define HPSM_PARAMS_SVH
`define HPSM_CLK_HZ 10000000
`define HPSM_FIXED_RST_NS 1000
`define HPSM_NUM_PORTS 4
`define HPSM_STRAP_RST 1'b1
`endif

/* File: pkg/hpsm_pkg.sv */
// types for the port power strap mux
package hpsm_pkg;
    typedef struct packed {
        logic [3:0] removable;
        logic port1_is_power;
        logic individual;
        logic rom_present;
        logic [2:0] led_opts;
    } hpsm_straps_t;
    typedef enum logic [1:0] {
        HPSM_SAMPLE,
        HPSM_FIXRST,
        HPSM_RUN
    } hpsm_state_t;
endpackage

/* File: dv/hpsm_far_side.sv */
// model of the power switches, strap resistors and serial rom
`timescale 1ns/1ps
module hpsm_far_side (
    input wire logic [9:0] strap_i,
    input wire logic [3:0] fault_i,
    input wire logic rom_bit_i,
    input wire logic ready_i,
    input wire logic [5:0] drv_i,
    input wire logic [5:0] oe_i,
    output logic [3:0] oc_n_o,
    output logic [5:0] pin_o
);
    logic [5:0] lvl;
    logic rom_sel;
    // switch flags low on fault; resistors show straps before run
    assign oc_n_o = ready_i ? ~fault_i : strap_i[9:6];
    // released pins fall back to their strap resistor level
    assign lvl = (oe_i & drv_i) | (~oe_i & strap_i[5:0]);
    assign rom_sel = oe_i[2] & ~drv_i[2];
    assign pin_o = {lvl[5:2], rom_sel ? rom_bit_i : lvl[1], lvl[0]};
endmodule

/* File: dv/hpsm_top_tb_top.sv */
// self-checking bench for the port power strap mux
`timescale 1ns/1ps
module hpsm_top_tb_top;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [9:0] strap = 10'h3FF;
    logic [3:0] fault = 4'h0, pwr = 4'h0, ind = 4'h0;
    logic fix = 1'b0, rom_bit = 1'b0;
    logic [2:0] rq = 3'h0, led, pn, pn_oe;
    logic [6:0] e;
    logic [3:0] oc_n, ovc, fixd;
    logic [5:0] pin, drv, oe;
    logic ind_m, rpres, rdy, miso, p1o, p1e, scko, scke;
    logic cso, cse, dio, die, doo, doe;
    int n_fail = 0, total_checks = 0;
    localparam logic [28:0] ROWS [4] = '{
        {10'b1111111101, 4'b0101, 4'h0, 1'b0, 3'b110, 7'b0101100},
        {10'b1111100110, 4'b0100, 4'h0, 1'b0, 3'b011, 7'b0000001},
        {10'b1110011001, 4'b1001, 4'hA, 1'b1, 3'b000, 7'b0011010},
        {10'b0101100011, 4'b0000, 4'h4, 1'b1, 3'b000, 7'b1111101}};
    assign drv = {p1o, pn[0], scko, cso, dio, doo};
    assign oe = {p1e, pn_oe[0], scke, cse, die, doe};
    hpsm_far_side u_far (.strap_i(strap), .fault_i(fault),
        .rom_bit_i(rom_bit), .ready_i(rdy), .drv_i(drv), .oe_i(oe),
        .oc_n_o(oc_n), .pin_o(pin));
    hpsm_top #(.FIXED_RST_NS(200)) DUT (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .portx_overcurrent_n_i(oc_n),
        .port1_pin_i(pin[5]), .port2_pin_i(pin[4]),
        .rom_serial_clock_i(pin[3]), .rom_select_n_i(pin[2]),
        .rom_data_in_i(pin[1]), .rom_data_out_i(pin[0]),
        .port_power_req_i(pwr), .port_indicator_req_i(ind),
        .fixed_reset_req_i(fix), .rom_sck_req_i(rq[2]),
        .rom_cs_req_i(rq[1]), .rom_mosi_req_i(rq[0]),
        .port_overcurrent_o(ovc), .port_fixed_o(fixd),
        .individual_mode_o(ind_m), .rom_present_o(rpres),
        .led_opts_o(led), .ready_o(rdy), .rom_miso_o(miso),
        .port1_power_on_n_o(p1o), .port1_power_on_n_oe_o(p1e),
        .portn_power_on_n_o(pn), .portn_power_on_n_oe_o(pn_oe),
        .rom_serial_clock_o(scko), .rom_serial_clock_oe_o(scke),
        .rom_select_n_o(cso), .rom_select_n_oe_o(cse),
        .rom_data_in_o(dio), .rom_data_in_oe_o(die),
        .rom_data_out_o(doo), .rom_data_out_oe_o(doe));
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // reset with straps on the pins, then run
    task automatic boot;
        srst_i = 1'b1;
        fault = 4'h0;
        tick(2);
        chk(8'({oe, rdy}), 8'h00);
        srst_i = 1'b0;
        tick(1);
        chk(8'(oe), 8'h00);
        tick(30);
        chk(8'(rdy), 8'h01);
    endtask
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            {strap, pwr, ind, fix, rq, e} = ROWS[i];
            boot();
            chk({4'h0, fixd}, {4'h0, ~strap[9:6]});
            chk({pn_oe, p1e, scke, cse, die, doe}, {3'h7, 1'b1, 1'b1,
                strap[2], ~strap[2], 1'b1});
            chk(8'({ind_m, rpres, led}), 8'({strap[4], strap[2],
                strap[3], strap[1], strap[0]}));
            chk(8'({p1o, pn, scko, doo}), 8'({e[6:2], e[0]}));
            if (!strap[2])
                chk(8'({dio, die}), 8'({e[1], 1'b1}));
            else
                chk(8'({cso, die}), 8'({~rq[1], 1'b0}));
        end
        // fixed ports never report over-current
        fault = 4'hF;
        tick(2);
        chk(8'(ovc), 8'h05);
        fault = 4'h1;
        tick(2);
        chk(8'(ovc), 8'h01);
        // fixed device reset follows the request once running
        {strap, pwr, ind, fix, rq, e} = ROWS[2];
        boot();
        fix = 1'b0;
        tick(2);
        chk(8'(p1o), 8'h01);
        {strap, pwr, ind, fix, rq, e} = ROWS[0];
        boot();
        rq = 3'b010;
        rom_bit = 1'b1;
        tick(3);
        chk(8'(miso), 8'h01);
        rom_bit = 1'b0;
        tick(3);
        chk(8'(miso), 8'h00);
        tally_and_finish;
    end
endmodule
